// ==== src/adcc_map.svh ====
// Register map, field positions, reset values and timing counts.
// Assumes an 8-bit register port with a 2-bit word address.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// Register indices
`define ADCC_A_SC 2'h0
`define ADCC_A_RH 2'h1
`define ADCC_A_RL 2'h2
`define ADCC_A_CK 2'h3
// Status/control fields
`define ADCC_SC_DONE 7
`define ADCC_SC_IEN 6
`define ADCC_SC_CONT 5
// Clock register justify field
`define ADCC_CK_JHI 3
`define ADCC_CK_JLO 2
`define ADCC_JUST_RST 2'h1
// Channel codes
`define ADCC_CH_OFF 5'h1f
`define ADCC_CH_REFL 5'h1e
`define ADCC_CH_REFH 5'h1d
// Timing in converter clock cycles
`define ADCC_SAMPLE_CYC 4'h6
`define ADCC_CONV_LAST 4'hf
`define ADCC_WARM_LAST 4'hf
`endif

// ==== src/adcc_pkg.sv ====
// Types shared by the converter control block.
// Assumes adcc_map.svh holds all numeric constants.
package adcc_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_warm = 4'b0010,
    st_conv = 4'b0100,
    st_stop = 4'b1000
  } adcc_state_e;
  typedef enum logic [1:0] {
    just_trunc = 2'h0,
    just_right = 2'h1,
    just_left = 2'h2,
    just_lsign = 2'h3
  } adcc_just_e;
  typedef logic [9:0] adcc_raw_t;
endpackage : adcc_pkg

// ==== src/adcc_conv_if.sv ====
// Handshake between the control logic and the approximation engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface adcc_conv_if;
  logic start;
  logic abort;
  logic busy;
  logic done;
  adcc_pkg::adcc_raw_t result;
  modport ctrl (output start, output abort, input busy, input done, input result);
  modport sar (input start, input abort, output busy, output done, output result);
endinterface : adcc_conv_if

// ==== src/adcc_sar.sv ====
// Successive approximation engine: sampling phase then ten decisions.
// Assumes cmp_above is a synchronous comparator answer for dac_code.
`timescale 1ns/1ns
module adcc_sar (
  input wire logic clk,
  input wire logic reset_n,
  adcc_conv_if.sar cv,
  input wire logic cmp_above,
  output logic [9:0] dac_code,
  output logic sample_en
);
  import adcc_pkg::*;
  `include "adcc_map.svh"

  logic [3:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [9:0] code_r;
  logic [9:0] code_nxt;
  logic [3:0] idx;

  // Decision on current trial bit, then set the next lower one
  always_comb begin
    idx = `ADCC_CONV_LAST - cnt_r;
    code_nxt = code_r;
    if (!cmp_above) begin
      code_nxt[idx] = 1'b0;
    end
    if (idx != 4'h0) begin
      code_nxt[idx - 4'h1] = 1'b1;
    end
  end

  // Sixteen cycles per conversion; start restarts even if busy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      code_r <= 10'h000;
    end else if (cv.start) begin
      busy_r <= 1'b1;
      cnt_r <= 4'h0;
      code_r <= 10'h000;
    end else if (cv.abort) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == `ADCC_SAMPLE_CYC - 4'h1) begin
        code_r <= 10'h200;
      end else if (cnt_r >= `ADCC_SAMPLE_CYC) begin
        code_r <= code_nxt;
      end
      if (cnt_r == `ADCC_CONV_LAST) begin
        busy_r <= 1'b0;
      end
    end
  end

  // One-cycle completion pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && !cv.start && !cv.abort && cnt_r == `ADCC_CONV_LAST;
    end
  end

  assign cv.busy = busy_r;
  assign cv.done = done_r;
  assign cv.result = code_r;
  assign dac_code = code_r;
  assign sample_en = busy_r && cnt_r < `ADCC_SAMPLE_CYC;
endmodule : adcc_sar

// ==== src/adcc_fmt.sv ====
// Result formatter: four layouts of the raw 10-bit code.
// Assumes raw is stable whenever the caller samples hi and lo.
`timescale 1ns/1ns
module adcc_fmt (
  input wire adcc_pkg::adcc_raw_t raw,
  input wire adcc_pkg::adcc_just_e just,
  output logic [7:0] hi,
  output logic [7:0] lo
);
  import adcc_pkg::*;

  // Layout by justify mode
  always_comb begin
    unique case (just)
      just_trunc: begin
        hi = 8'h00;
        lo = raw[9:2];
      end
      just_right: begin
        hi = {6'h00, raw[9:8]};
        lo = raw[7:0];
      end
      just_left: begin
        hi = raw[9:2];
        lo = {raw[1:0], 6'h00};
      end
      just_lsign: begin
        hi = {~raw[9], raw[8:2]};
        lo = {raw[1:0], 6'h00};
      end
    endcase
  end
endmodule : adcc_fmt

// ==== src/adcc_top.sv ====
// Converter control: registers, sequencing, result formatting.
// Assumes clk is the converter clock; all inputs are synchronous to it.
// Assumes stop_mode is synchronous to clk and held for the whole stop.
//
// Functional notes
// - Status write starts conversion of 16-17 cycles
// - Continuous mode overwrites unread results
// - Continuous conversions run until bit cleared
// - Single mode: one conversion per write
// - Done flag set, held until data read
// - Interrupt mode: flag reads zero, request raised
// - Request dropped on data read, control write
// - Reset clears flag, interrupt and continuous enables
// - Codes 0 to 23 select inputs
// - All ones powers off; 16-cycle recovery
// - The two codes below all ones select references
// - Justify field selects format; reset right
// - Left: eight high bits in high register
// - Right: two high bits in high register
// - Signed left: top bit inverted
// - Truncation: eight top bits low, no interlock
// - Unread low register blocks new results after a high read
// - High read freezes low until read
// - Runs in wait; request can wake
// - Stop aborts; resume after 16-cycle stabilisation
`timescale 1ns/1ns
module adcc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic cmp_above,
  output logic [9:0] dac_code,
  output logic sample_en,
  output logic [4:0] mux_sel,
  output logic ref_hi_sel,
  output logic ref_lo_sel,
  output logic analog_power_on,
  output logic conv_irq
);
  import adcc_pkg::*;
  `include "adcc_map.svh"

  // ****************************************
  // Declarations
  // ****************************************
  // Control-to-engine bundle
  adcc_conv_if cv ();

  adcc_state_e state_r;
  adcc_state_e state_nxt;
  adcc_just_e just_r;
  logic cont_r;
  logic ien_r;
  logic [4:0] chan_r;
  logic done_flag_r;
  logic irq_r;
  logic [7:0] rh_r;
  logic [7:0] rl_r;
  logic lock_r;
  logic warm_need_r;
  logic [3:0] warm_cnt_r;
  logic pend_r;
  logic [7:0] rdata_r;
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  logic sc_wr;
  logic ck_wr;
  logic rd_hi;
  logic rd_lo;
  logic data_rd;
  logic launch;
  logic abort;
  logic store_ok;

  // ****************************************
  // Register port decode
  // ****************************************
  // Strobes are single cycle, so each decode is a one-cycle event
  assign sc_wr = wr_stb && addr == `ADCC_A_SC;
  assign ck_wr = wr_stb && addr == `ADCC_A_CK;
  assign rd_hi = rd_stb && addr == `ADCC_A_RH;
  assign rd_lo = rd_stb && addr == `ADCC_A_RL;
  assign data_rd = rd_hi || rd_lo;

  // Control fields; the done-flag position of a write is ignored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ien_r <= 1'b0;
      cont_r <= 1'b0;
    end else if (sc_wr) begin
      ien_r <= wdata[`ADCC_SC_IEN];
      cont_r <= wdata[`ADCC_SC_CONT];
    end
  end

  // Channel select; resets to power-off so the analog side starts quiet
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_r <= `ADCC_CH_OFF;
    end else if (sc_wr) begin
      chan_r <= wdata[4:0];
    end
  end

  // Justify field; other clock bits are not held here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      just_r <= adcc_just_e'(`ADCC_JUST_RST);
    end else if (ck_wr) begin
      just_r <= adcc_just_e'(wdata[`ADCC_CK_JHI:`ADCC_CK_JLO]);
    end
  end

  // ****************************************
  // Sequencing
  // ****************************************
  // Stop overrides everything; a control write abandons any
  // conversion in flight and reissues one unless the new channel is off.
  // Single mode falls back to idle after one result.
  always_comb begin
    state_nxt = state_r;
    launch = 1'b0;
    abort = 1'b0;
    if (stop_mode) begin
      if (state_r != st_stop) begin
        abort = 1'b1;
        state_nxt = st_stop;
      end
    end else if (sc_wr) begin
      abort = 1'b1;
      if (wdata[4:0] == `ADCC_CH_OFF) begin
        state_nxt = st_idle;
      end else if (warm_need_r) begin
        state_nxt = st_warm;
      end else begin
        launch = 1'b1;
        state_nxt = st_conv;
      end
    end else begin
      unique case (state_r)
        st_idle: begin
          state_nxt = st_idle;
        end
        st_warm: begin
          if (warm_cnt_r == `ADCC_WARM_LAST) begin
            launch = 1'b1;
            state_nxt = st_conv;
          end
        end
        st_conv: begin
          if (cv.done) begin
            if (cont_r) begin
              launch = 1'b1;
            end else begin
              state_nxt = st_idle;
            end
          end else if (!cv.busy) begin
            // Engine idle with no result pending: never wait here forever
            state_nxt = st_idle;
          end
        end
        st_stop: begin
          // Resume only what was running, after a settling period
          if ((pend_r || cont_r) && chan_r != `ADCC_CH_OFF) begin
            state_nxt = st_warm;
          end else begin
            state_nxt = st_idle;
          end
        end
        default: begin
          state_nxt = st_idle;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settling counter, one full conversion period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      warm_cnt_r <= 4'h0;
    end else if (state_r == st_warm && state_nxt == st_warm) begin
      warm_cnt_r <= warm_cnt_r + 4'h1;
    end else begin
      warm_cnt_r <= 4'h0;
    end
  end

  // Analog needs settling after power-off or stop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      warm_need_r <= 1'b1;
    end else if (stop_mode) begin
      warm_need_r <= 1'b1;
    end else if (sc_wr && wdata[4:0] == `ADCC_CH_OFF) begin
      warm_need_r <= 1'b1;
    end else if (state_r == st_warm && launch) begin
      warm_need_r <= 1'b0;
    end
  end

  // A single conversion is owed until its result lands
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
    end else if (sc_wr) begin
      pend_r <= wdata[4:0] != `ADCC_CH_OFF;
    end else if (cv.done && state_r == st_conv) begin
      pend_r <= 1'b0;
    end
  end

  // Engine handshake; inside the engine start outranks abort
  assign cv.start = launch;
  assign cv.abort = abort;

  // Comparator is on clk, so the engine reads it with no synchroniser
  adcc_sar u_sar (
    .clk(clk),
    .reset_n(reset_n),
    .cv(cv),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .sample_en(sample_en)
  );

  // ****************************************
  // Result registers
  // ****************************************
  adcc_fmt u_fmt (
    .raw(cv.result),
    .just(just_r),
    .hi(fmt_hi),
    .lo(fmt_lo)
  );

  // High read locks the pair until low is read; truncation has none
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_r <= 1'b0;
    end else if (rd_lo || just_r == just_trunc) begin
      lock_r <= 1'b0;
    end else if (rd_hi) begin
      lock_r <= 1'b1;
    end
  end

  // Also blocked in the cycle of the high read, keeping the pair whole
  assign store_ok = just_r == just_trunc || (!lock_r && !rd_hi);

  // Each completion overwrites, read or not, unless locked
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rh_r <= 8'h00;
      rl_r <= 8'h00;
    end else if (cv.done && store_ok) begin
      rh_r <= fmt_hi;
      rl_r <= fmt_lo;
    end
  end

  // ****************************************
  // Completion flag and request
  // ****************************************
  // A completion in the same cycle as the read keeps the flag set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_flag_r <= 1'b0;
    end else if (cv.done && !ien_r) begin
      done_flag_r <= 1'b1;
    end else if (data_rd) begin
      done_flag_r <= 1'b0;
    end
  end

  // Request stays up in wait mode so it can wake the core
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else if (cv.done && ien_r) begin
      irq_r <= 1'b1;
    end else if (data_rd || sc_wr) begin
      irq_r <= 1'b0;
    end
  end

  assign conv_irq = irq_r;

  // ****************************************
  // Read data
  // ****************************************
  // Valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        `ADCC_A_SC: begin
          rdata_r <= {done_flag_r && !ien_r, ien_r, cont_r, chan_r};
        end
        `ADCC_A_RH: begin
          rdata_r <= rh_r;
        end
        `ADCC_A_RL: begin
          rdata_r <= rl_r;
        end
        `ADCC_A_CK: begin
          rdata_r <= {4'h0, just_r, 2'h0};
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Read data straight from a flip-flop
  assign rdata = rdata_r;

  // ****************************************
  // Analog front-end controls
  // ****************************************
  // Unused codes pass through; the result is then undefined
  assign mux_sel = chan_r;
  assign ref_hi_sel = chan_r == `ADCC_CH_REFH;
  assign ref_lo_sel = chan_r == `ADCC_CH_REFL;
  assign analog_power_on = chan_r != `ADCC_CH_OFF && state_r != st_stop;

endmodule : adcc_top

// ==== tb/adcc_properties.sv ====
// Port checker for the converter control block.
// Assumes it is bound to adcc_top and sees only its ports.
`timescale 1ns/1ns
module adcc_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic cmp_above,
  input wire logic [9:0] dac_code,
  input wire logic sample_en,
  input wire logic [4:0] mux_sel,
  input wire logic ref_hi_sel,
  input wire logic ref_lo_sel,
  input wire logic analog_power_on,
  input wire logic conv_irq
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  power_off_a: assert property (mux_sel == 5'h1f |-> !analog_power_on)
    else $error("converter powered with channel off");
  ref_high_a: assert property (ref_hi_sel == (mux_sel == 5'h1d))
    else $error("upper reference decode wrong");
  ref_low_a: assert property (ref_lo_sel == (mux_sel == 5'h1e))
    else $error("lower reference decode wrong");
  sample_power_a: assert property (sample_en |-> analog_power_on)
    else $error("sampling while powered off");
  flag_masked_a: assert property (rd_stb && addr == 2'h0 |=> !(rdata[7] && rdata[6]))
    else $error("done flag set in interrupt mode");
  stop_halt_a: assert property (stop_mode ##1 stop_mode |-> !sample_en && !analog_power_on)
    else $error("converter active in stop");
  // Sampling length since the last start; a status write restarts it
  logic [3:0] samp_cnt_r;
  always_ff @(posedge clk) begin
    if (!reset_n || !sample_en || (wr_stb && addr == 2'h0)) begin
      samp_cnt_r <= 4'h0;
    end else if (samp_cnt_r != 4'hf) begin
      samp_cnt_r <= samp_cnt_r + 4'h1;
    end
  end
  // Aborted phases are excused, only full sampling phases are measured
  sample_len_a: assert property ($fell(sample_en) && !$past(wr_stb) && !$past(stop_mode)
    |-> samp_cnt_r == 4'h6)
    else $error("sampling phase not six cycles");
  cover property ($rose(conv_irq));
  cover property ($fell(stop_mode));
  cover property (rd_stb && addr == 2'h2);
endmodule : adcc_properties

bind adcc_top adcc_properties adcc_properties_inst (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .stop_mode(stop_mode), .cmp_above(cmp_above), .dac_code(dac_code),
  .sample_en(sample_en), .mux_sel(mux_sel), .ref_hi_sel(ref_hi_sel),
  .ref_lo_sel(ref_lo_sel), .analog_power_on(analog_power_on), .conv_irq(conv_irq));

// ==== tb/adcc_top_tb.sv ====
// Self-checking bench: reset checks, format table, then hand-written cases.
// Assumes an ideal comparator that answers from the trial code at once.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module adcc_top_tb;
  import adcc_pkg::*;
  typedef struct {logic [1:0] j; logic [4:0] ch; logic [9:0] v; logic [7:0] h, l;} adcc_row_s;
  // Four layouts of two codes; last channel is reused below
  adcc_row_s rows [8] = '{'{2'h0, 5'h00, 10'h2a5, 8'h00, 8'ha9},
    '{2'h1, 5'h17, 10'h2a5, 8'h02, 8'ha5}, '{2'h2, 5'h1d, 10'h2a5, 8'ha9, 8'h40},
    '{2'h3, 5'h1e, 10'h2a5, 8'h29, 8'h40}, '{2'h0, 5'h05, 10'h103, 8'h00, 8'h40},
    '{2'h1, 5'h10, 10'h103, 8'h01, 8'h03}, '{2'h2, 5'h0a, 10'h103, 8'h40, 8'hc0},
    '{2'h3, 5'h16, 10'h103, 8'hc0, 8'hc0}};
  logic clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, stop_mode = 0;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [9:0] vin, dac_code;
  logic [4:0] mux_sel;
  logic sample_en, ref_hi_sel, ref_lo_sel, analog_power_on, conv_irq, cmp_above;
  int err_total = 0, check_count = 0, n;
  // ****************
  // Clock, comparator, device
  // ****************
  always #5 clk = ~clk;
  assign cmp_above = vin >= dac_code; // Ideal converter: result equals vin
  adcc_top adcc_top_inst (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .stop_mode(stop_mode),
    .cmp_above(cmp_above), .dac_code(dac_code), .sample_en(sample_en), .mux_sel(mux_sel),
    .ref_hi_sel(ref_hi_sel), .ref_lo_sel(ref_lo_sel), .analog_power_on(analog_power_on),
    .conv_irq(conv_irq));
  // ****************
  // Bus and wait tasks
  // ****************
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata; // Data stands only in the cycle after the strobe
  endtask : rd
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Polls the done flag; a status read leaves it set
  task automatic wait_flag;
    n = 0;
    do begin
      rd(2'h0, d);
      n++;
    end while (d[7] !== 1'b1 && n < 40);
    `CHK("done_wait", 1'b1, d[7])
    if (d[7] !== 1'b1) print_verdict();
  endtask : wait_flag
  task automatic wait_irq;
    n = 0;
    while (conv_irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("irq_wait", 1'b1, conv_irq)
    if (conv_irq !== 1'b1) print_verdict();
  endtask : wait_irq
  // ****************
  // Main sequence
  // ****************
  initial begin
    addr = 2'h0;
    wdata = 8'h00;
    vin = 10'h000;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(2'h0, d);
    `CHK("sc_rst", 8'h1f, d)
    rd(2'h3, d);
    `CHK("ck_rst", 8'h04, d)
    `CHK("irq_rst", 1'b0, conv_irq)
    $display("test reset done");
    foreach (rows[i]) begin
      wr(2'h3, {4'h0, rows[i].j, 2'h0});
      vin <= rows[i].v;
      wr(2'h0, {3'h0, rows[i].ch});
      wait_flag();
      `CHK("mux", rows[i].ch, mux_sel)
      `CHK("refh", rows[i].ch == 5'h1d, ref_hi_sel)
      `CHK("refl", rows[i].ch == 5'h1e, ref_lo_sel)
      rd(2'h1, d);
      `CHK("rh", rows[i].h, d)
      rd(2'h2, d);
      `CHK("rl", rows[i].l, d)
    end
    repeat (40) @(posedge clk);
    rd(2'h0, d);
    `CHK("single", 8'h16, d)
    $display("test formats done");
    // Continuous run with the pair locked by a high read
    wr(2'h3, 8'h04);
    vin <= 10'h2a5;
    wr(2'h0, 8'h20);
    wait_flag();
    rd(2'h1, d);
    `CHK("rh_lock", 8'h02, d)
    @(posedge clk) vin <= 10'h103;
    repeat (59) @(posedge clk);
    rd(2'h2, d);
    `CHK("rl_frozen", 8'ha5, d)
    wait_flag();
    rd(2'h1, d);
    `CHK("rh_new", 8'h01, d)
    rd(2'h2, d);
    `CHK("rl_new", 8'h03, d)
    wr(2'h0, 8'h1f);
    #1 `CHK("pwr_off", 1'b0, analog_power_on)
    rd(2'h2, d); // Interrupted result discarded
    repeat (40) @(posedge clk);
    rd(2'h0, d);
    `CHK("cont_off", 8'h1f, d)
    $display("test continuous done");
    // Interrupt mode: flag hidden, request dropped by read and by write
    @(posedge clk) vin <= 10'h3ff;
    wr(2'h0, 8'h47);
    wait_irq();
    rd(2'h0, d);
    `CHK("flag_ien", 8'h47, d)
    rd(2'h2, d);
    `CHK("rl_full", 8'hff, d)
    `CHK("irq_rd", 1'b0, conv_irq)
    wr(2'h0, 8'h47);
    wait_irq();
    wr(2'h0, 8'h1f);
    #1 `CHK("irq_wr", 1'b0, conv_irq)
    $display("test interrupt done");
    // Stop in mid-conversion, then resume
    @(posedge clk) vin <= 10'h155;
    wr(2'h0, 8'h08);
    repeat (24) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (10) @(posedge clk);
    rd(2'h0, d);
    `CHK("stop_abort", 8'h08, d)
    @(posedge clk) stop_mode <= 1'b0;
    wait_flag();
    rd(2'h2, d);
    `CHK("rl_stop", 8'h55, d)
    $display("test stop done");
    // Reset in mid-run with flag, request and continuous mode all set
    wr(2'h3, 8'h08);
    wr(2'h0, 8'h25);
    wait_flag();
    wr(2'h0, 8'h65);
    wait_irq();
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(2'h0, d);
    `CHK("sc_rerst", 8'h1f, d)
    rd(2'h3, d);
    `CHK("ck_rerst", 8'h04, d)
    `CHK("irq_rerst", 1'b0, conv_irq)
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : adcc_top_tb
